// *** rtl/cpu_regs.sv ***
// program and system register file of the cpu
`timescale 1ns/1ps
`include "cpu_regs_regs.svh"
module cpu_regs
  import cpu_regs_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int NUM_GPR = 32
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  // general register ports: two reads, one write
  input wire logic [4:0] I_GPR_RADDR_A,
  input wire logic [4:0] I_GPR_RADDR_B,
  input wire logic I_SHORT_MEM_INSTR,
  input wire logic I_GPR_WE,
  input wire logic [4:0] I_GPR_WADDR,
  input wire logic [31:0] I_GPR_WDATA,
  // program counter control
  input wire logic [1:0] I_PC_OP,
  input wire logic [31:0] I_PC_OPERAND,
  input wire logic [1:0] I_RET_SRC,
  // system register access
  input wire logic I_LOAD_SYSREG_INSTR,
  input wire logic I_STORE_SYSREG_INSTR,
  input wire logic [4:0] I_SYSREG_NUM,
  input wire logic [31:0] I_SYSREG_WDATA,
  input wire logic I_DEBUG_TRAP_INSTR,
  // hardware updates of the interrupt source and status word
  input wire logic I_ISRC_WE,
  input wire logic [31:0] I_ISRC_DATA,
  input wire logic I_PSW_HW_WE,
  input wire logic [31:0] I_PSW_HW_DATA,
  output logic [31:0] O_GPR_RDATA_A,
  output logic [31:0] O_GPR_RDATA_B,
  output logic [31:0] O_PC,
  output logic [31:0] O_SYSREG_RDATA,
  output logic [31:0] O_PSW
);

  // ==========================================================================
  // general registers
  // ==========================================================================
  word_type gpr_reg [NUM_GPR];
  regnum_type raddr_a;
  word_type rdata_a_next;
  word_type rdata_b_next;
  logic gpr_wr_ok;

  // short-format memory access reads the element base register implicitly
  assign raddr_a = I_SHORT_MEM_INSTR ? `GPR_ELEMENT_BASE
    : I_GPR_RADDR_A;

  // a write to the zero register is dropped here, so it never lands
  assign gpr_wr_ok = I_GPR_WE && I_GPR_WADDR != `GPR_ZERO;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_reg[i] <= `REG_RESET;
      end
    end else if (gpr_wr_ok) begin
      gpr_reg[I_GPR_WADDR] <= I_GPR_WDATA;
    end
  end

  // reads bypass a same-cycle write so the pipeline sees the newest value
  always_comb begin
    if (raddr_a == `GPR_ZERO) begin
      rdata_a_next = '0;
    end else if (I_GPR_WE && I_GPR_WADDR == raddr_a) begin
      rdata_a_next = I_GPR_WDATA;
    end else begin
      rdata_a_next = gpr_reg[raddr_a];
    end
  end

  always_comb begin
    if (I_GPR_RADDR_B == `GPR_ZERO) begin
      rdata_b_next = '0;
    end else if (I_GPR_WE && I_GPR_WADDR == I_GPR_RADDR_B) begin
      rdata_b_next = I_GPR_WDATA;
    end else begin
      rdata_b_next = gpr_reg[I_GPR_RADDR_B];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_GPR_RDATA_A <= '0;
    end else begin
      O_GPR_RDATA_A <= rdata_a_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_GPR_RDATA_B <= '0;
    end else begin
      O_GPR_RDATA_B <= rdata_b_next;
    end
  end

  // ==========================================================================
  // system registers
  // ==========================================================================
  // single copy of each; nested interrupts must save them in software
  word_type irq_return_pc_reg;
  word_type irq_saved_status_reg;
  word_type nmi_return_pc_reg;
  word_type nmi_saved_status_reg;
  word_type interrupt_source_code_reg;
  word_type processor_status_word_reg;
  word_type table_call_return_pc_reg;
  word_type table_call_saved_status_reg;
  word_type debug_return_pc_reg;
  word_type debug_saved_status_reg;
  word_type table_call_base_pointer_reg;
  logic ld;
  word_type sysreg_rdata_next;

  assign ld = I_LOAD_SYSREG_INSTR;

  // ==========================================================================
  // load strobes
  // ==========================================================================
  // one strobe per writable number; 4 and the reserved numbers get none
  logic ld_irq_pc;
  logic ld_irq_st;
  logic ld_nmi_pc;
  logic ld_nmi_st;
  logic ld_status;
  logic ld_tc_pc;
  logic ld_tc_st;
  logic ld_tc_base;
  logic ld_dbg;
  logic ld_dbg_pc;
  logic ld_dbg_st;

  assign ld_irq_pc = ld && I_SYSREG_NUM == `SR_IRQ_RETURN_PC;
  assign ld_irq_st = ld && I_SYSREG_NUM == `SR_IRQ_SAVED_STATUS;
  assign ld_nmi_pc = ld && I_SYSREG_NUM == `SR_NMI_RETURN_PC;
  assign ld_nmi_st = ld && I_SYSREG_NUM == `SR_NMI_SAVED_STATUS;
  assign ld_status = ld && I_SYSREG_NUM == `SR_PROCESSOR_STATUS_WORD;
  assign ld_tc_pc = ld && I_SYSREG_NUM == `SR_TABLE_CALL_RETURN_PC;
  assign ld_tc_st = ld && I_SYSREG_NUM == `SR_TABLE_CALL_SAVED_STATUS;
  assign ld_tc_base = ld && I_SYSREG_NUM == `SR_TABLE_CALL_BASE_POINTER;

  // debug save registers only accept a load inside the debug trap
  assign ld_dbg = ld && I_DEBUG_TRAP_INSTR;
  assign ld_dbg_pc = ld_dbg && I_SYSREG_NUM == `SR_DEBUG_RETURN_PC;
  assign ld_dbg_st = ld_dbg && I_SYSREG_NUM == `SR_DEBUG_SAVED_STATUS;

  // ==========================================================================
  // saved registers
  // ==========================================================================
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_return_pc_reg <= `REG_RESET;
    end else if (ld_irq_pc) begin
      irq_return_pc_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      irq_saved_status_reg <= `REG_RESET;
    end else if (ld_irq_st) begin
      irq_saved_status_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      nmi_return_pc_reg <= `REG_RESET;
    end else if (ld_nmi_pc) begin
      nmi_return_pc_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      nmi_saved_status_reg <= `REG_RESET;
    end else if (ld_nmi_st) begin
      nmi_saved_status_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      table_call_return_pc_reg <= `REG_RESET;
    end else if (ld_tc_pc) begin
      table_call_return_pc_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      table_call_saved_status_reg <= `REG_RESET;
    end else if (ld_tc_st) begin
      table_call_saved_status_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      table_call_base_pointer_reg <= `REG_RESET;
    end else if (ld_tc_base) begin
      table_call_base_pointer_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      debug_return_pc_reg <= `REG_RESET;
    end else if (ld_dbg_pc) begin
      debug_return_pc_reg <= I_SYSREG_WDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      debug_saved_status_reg <= `REG_RESET;
    end else if (ld_dbg_st) begin
      debug_saved_status_reg <= I_SYSREG_WDATA;
    end
  end

  // ==========================================================================
  // hardware-updated registers
  // ==========================================================================
  // interrupt source is written only by hardware, never by a load
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      interrupt_source_code_reg <= `REG_RESET;
    end else if (I_ISRC_WE) begin
      interrupt_source_code_reg <= I_ISRC_DATA;
    end
  end

  // software load wins over a hardware flag update in the same cycle
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      processor_status_word_reg <= `PSW_RESET;
    end else if (ld_status) begin
      processor_status_word_reg <= I_SYSREG_WDATA;
    end else if (I_PSW_HW_WE) begin
      processor_status_word_reg <= I_PSW_HW_DATA;
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  always_comb begin
    sysreg_rdata_next = '0;
    case (I_SYSREG_NUM)
      `SR_IRQ_RETURN_PC: sysreg_rdata_next = irq_return_pc_reg;
      `SR_IRQ_SAVED_STATUS: sysreg_rdata_next = irq_saved_status_reg;
      `SR_NMI_RETURN_PC: sysreg_rdata_next = nmi_return_pc_reg;
      `SR_NMI_SAVED_STATUS: sysreg_rdata_next = nmi_saved_status_reg;
      `SR_INTERRUPT_SOURCE_CODE: begin
        sysreg_rdata_next = interrupt_source_code_reg;
      end
      `SR_PROCESSOR_STATUS_WORD: begin
        sysreg_rdata_next = processor_status_word_reg;
      end
      `SR_TABLE_CALL_RETURN_PC: sysreg_rdata_next = table_call_return_pc_reg;
      `SR_TABLE_CALL_SAVED_STATUS: begin
        sysreg_rdata_next = table_call_saved_status_reg;
      end
      `SR_DEBUG_RETURN_PC: sysreg_rdata_next = debug_return_pc_reg;
      `SR_DEBUG_SAVED_STATUS: sysreg_rdata_next = debug_saved_status_reg;
      `SR_TABLE_CALL_BASE_POINTER: begin
        sysreg_rdata_next = table_call_base_pointer_reg;
      end
      default: sysreg_rdata_next = '0;
    endcase
  end

  // read data holds its last value between store instructions
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_SYSREG_RDATA <= '0;
    end else if (I_STORE_SYSREG_INSTR) begin
      O_SYSREG_RDATA <= sysreg_rdata_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_PSW <= `PSW_RESET;
    end else if (ld_status) begin
      O_PSW <= I_SYSREG_WDATA;
    end else if (I_PSW_HW_WE) begin
      O_PSW <= I_PSW_HW_DATA;
    end
  end

  // ==========================================================================
  // program counter
  // ==========================================================================
  logic [`PC_VALID_BITS-1:0] pc_reg;
  logic [`PC_VALID_BITS-1:0] pc_next;
  word_type ret_pc;

  always_comb begin
    case (ret_src_type'(I_RET_SRC))
      RET_IRQ: ret_pc = irq_return_pc_reg;
      RET_NMI: ret_pc = nmi_return_pc_reg;
      RET_TABLE: ret_pc = table_call_return_pc_reg;
      RET_DEBUG: ret_pc = debug_return_pc_reg;
      default: ret_pc = irq_return_pc_reg;
    endcase
  end

  // the sum is cut to 26 bits, so a carry out of bit 25 is lost
  always_comb begin
    case (pc_op_type'(I_PC_OP))
      PC_HOLD: pc_next = pc_reg;
      PC_ADD: pc_next = pc_reg + I_PC_OPERAND[`PC_VALID_BITS-1:0];
      PC_LOAD: pc_next = I_PC_OPERAND[`PC_VALID_BITS-1:0];
      PC_RETURN: pc_next = ret_pc[`PC_VALID_BITS-1:0];
      default: pc_next = pc_reg;
    endcase
    pc_next[0] = 1'b0;
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pc_reg <= `PC_VALID_BITS'(`PC_RESET);
    end else begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_PC <= `PC_RESET;
    end else begin
      O_PC <= {{(WIDTH - `PC_VALID_BITS){1'b0}}, pc_next};
    end
  end

endmodule // cpu_regs

// *** rtl/cpu_regs_pkg.sv ***
// types shared by the cpu register file
package cpu_regs_pkg;
  typedef logic [31:0] word_type;
  typedef logic [4:0] regnum_type;
  // how the program counter is updated this cycle
  typedef enum logic [1:0] {
    PC_HOLD = 2'b00,
    PC_ADD = 2'b01,
    PC_LOAD = 2'b11,
    PC_RETURN = 2'b10
  } pc_op_type;
  // which saved pc a return reloads
  typedef enum logic [1:0] {
    RET_IRQ = 2'b00,
    RET_NMI = 2'b01,
    RET_TABLE = 2'b11,
    RET_DEBUG = 2'b10
  } ret_src_type;
endpackage

// *** rtl/cpu_regs_regs.svh ***
// register numbers, field positions and reset values of the cpu register file
// Function
// - thirty-two general registers, each usable as data or address operand.
// - general register 0 always reads zero; writes to it are ignored.
// - short load/store use general register 30 as implicit base.
// - program counter keeps 26 bits; bits 31 to 26 read zero.
// - carry out of program counter bit 25 is discarded on add.
// - program counter bit 0 is always zero.
// - system register chosen by number; load writes it, store reads it.
// - system numbers 0-5 and 16-20 map to the named registers.
// - interrupt source register is readable but not writable.
// - system numbers 6-15 and 21-31 are reserved.
// - debug save registers take writes only during the debug trap.
// - bit 0 of a saved return pc is dropped on return.
// - one copy only of the interrupt return pc and status.
// - every register except the program counter (26 bits) is 32 bits wide.
`ifndef CPU_REGS_REGS_SVH
`define CPU_REGS_REGS_SVH
`define SR_IRQ_RETURN_PC 5'h00
`define SR_IRQ_SAVED_STATUS 5'h01
`define SR_NMI_RETURN_PC 5'h02
`define SR_NMI_SAVED_STATUS 5'h03
`define SR_INTERRUPT_SOURCE_CODE 5'h04
`define SR_PROCESSOR_STATUS_WORD 5'h05
`define SR_TABLE_CALL_RETURN_PC 5'h10
`define SR_TABLE_CALL_SAVED_STATUS 5'h11
`define SR_DEBUG_RETURN_PC 5'h12
`define SR_DEBUG_SAVED_STATUS 5'h13
`define SR_TABLE_CALL_BASE_POINTER 5'h14
`define GPR_ZERO 5'h00
`define GPR_ELEMENT_BASE 5'h1e
`define PC_VALID_BITS 26
`define PSW_RESET 32'h00000020
`define PC_RESET 32'h00000000
`define REG_RESET 32'h00000000
`endif

// *** verif/cpu_pipe_model.sv ***
// pipeline-side driver of the cpu register file
`timescale 1ns/1ps
module cpu_pipe_model
  import cpu_regs_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic [31:0] O_GPR_RDATA_A, O_GPR_RDATA_B, O_PC,
  input wire logic [31:0] O_SYSREG_RDATA, O_PSW,
  output logic [4:0] I_GPR_RADDR_A, I_GPR_RADDR_B, I_GPR_WADDR,
  output logic [4:0] I_SYSREG_NUM,
  output logic I_SHORT_MEM_INSTR, I_GPR_WE, I_LOAD_SYSREG_INSTR,
  output logic I_STORE_SYSREG_INSTR, I_DEBUG_TRAP_INSTR, I_ISRC_WE,
  output logic I_PSW_HW_WE,
  output logic [1:0] I_PC_OP, I_RET_SRC,
  output logic [31:0] I_GPR_WDATA, I_PC_OPERAND, I_SYSREG_WDATA,
  output logic [31:0] I_ISRC_DATA, I_PSW_HW_DATA
);
  initial begin
    {I_GPR_RADDR_A, I_GPR_RADDR_B, I_GPR_WADDR, I_SYSREG_NUM} = '0;
    {I_SHORT_MEM_INSTR, I_GPR_WE, I_LOAD_SYSREG_INSTR} = '0;
    {I_STORE_SYSREG_INSTR, I_DEBUG_TRAP_INSTR, I_ISRC_WE, I_PSW_HW_WE} = '0;
    {I_PC_OP, I_RET_SRC, I_GPR_WDATA, I_PC_OPERAND} = '0;
    {I_SYSREG_WDATA, I_ISRC_DATA, I_PSW_HW_DATA} = '0;
  end
  // released data is inverted so a stale value can never look valid
  task automatic gpr_wr(input regnum_type r, input word_type d);
    @(negedge I_MCLK);
    {I_GPR_WE, I_GPR_WADDR, I_GPR_WDATA} = {1'b1, r, d};
    @(negedge I_MCLK);
    {I_GPR_WE, I_GPR_WDATA} = {1'b0, ~d};
  endtask
  task automatic gpr_rd(input regnum_type ra, rb, input logic s,
                        output word_type da, db);
    @(negedge I_MCLK);
    {I_GPR_RADDR_A, I_GPR_RADDR_B, I_SHORT_MEM_INSTR} = {ra, rb, s};
    @(negedge I_MCLK);
    {da, db, I_SHORT_MEM_INSTR} = {O_GPR_RDATA_A, O_GPR_RDATA_B, 1'b0};
  endtask
  task automatic sys_wr(input regnum_type n, input word_type d,
                        input logic t);
    @(negedge I_MCLK);
    {I_LOAD_SYSREG_INSTR, I_SYSREG_NUM, I_SYSREG_WDATA} = {1'b1, n, d};
    I_DEBUG_TRAP_INSTR = t;
    @(negedge I_MCLK);
    {I_LOAD_SYSREG_INSTR, I_DEBUG_TRAP_INSTR, I_SYSREG_WDATA} = {2'b00, ~d};
  endtask
  task automatic sys_rd(input regnum_type n, output word_type d);
    @(negedge I_MCLK);
    {I_STORE_SYSREG_INSTR, I_SYSREG_NUM} = {1'b1, n};
    @(negedge I_MCLK);
    {I_STORE_SYSREG_INSTR, d} = {1'b0, O_SYSREG_RDATA};
  endtask
  task automatic pc_op(input pc_op_type op, input word_type v,
                       input ret_src_type s, output word_type p);
    @(negedge I_MCLK);
    {I_PC_OP, I_PC_OPERAND, I_RET_SRC} = {op, v, s};
    @(negedge I_MCLK);
    {I_PC_OP, p} = {PC_HOLD, O_PC};
  endtask
  task automatic isrc_wr(input word_type d);
    @(negedge I_MCLK);
    {I_ISRC_WE, I_ISRC_DATA} = {1'b1, d};
    @(negedge I_MCLK);
    {I_ISRC_WE, I_ISRC_DATA} = {1'b0, ~d};
  endtask
  // write and read the same register in one cycle to reach the bypass
  task automatic gpr_wr_rd(input regnum_type r, input word_type d,
                           output word_type db);
    @(negedge I_MCLK);
    {I_GPR_WE, I_GPR_WADDR, I_GPR_WDATA, I_GPR_RADDR_B} = {1'b1, r, d, r};
    @(negedge I_MCLK);
    {I_GPR_WE, I_GPR_WDATA, db} = {1'b0, ~d, O_GPR_RDATA_B};
  endtask
  // hardware status update, optionally colliding with a software load
  task automatic psw_wr(input word_type d, input logic l);
    @(negedge I_MCLK);
    {I_PSW_HW_WE, I_PSW_HW_DATA} = {1'b1, d};
    {I_LOAD_SYSREG_INSTR, I_SYSREG_NUM, I_SYSREG_WDATA} = {l, 5'h05, ~d};
    @(negedge I_MCLK);
    {I_PSW_HW_WE, I_LOAD_SYSREG_INSTR, I_PSW_HW_DATA} = {2'b00, ~d};
  endtask
endmodule // cpu_pipe_model

// *** verif/cpu_regs_properties.sv ***
// port assertions for the cpu register file
`timescale 1ns/1ps
module cpu_regs_properties
  import cpu_regs_pkg::*;
(
  input wire logic I_MCLK, I_RST, I_SHORT_MEM_INSTR, I_GPR_WE,
  input wire logic I_LOAD_SYSREG_INSTR, I_STORE_SYSREG_INSTR,
  input wire logic [1:0] I_PC_OP,
  input wire logic [4:0] I_GPR_RADDR_B, I_GPR_WADDR, I_SYSREG_NUM,
  input wire logic [31:0] I_GPR_WDATA, I_PC_OPERAND, I_SYSREG_WDATA,
  input wire logic [31:0] O_GPR_RDATA_A, O_GPR_RDATA_B, O_PC,
  input wire logic [31:0] O_SYSREG_RDATA, O_PSW
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic rsv;
  assign rsv = I_SYSREG_NUM inside {[5'h06:5'h0f], [5'h15:5'h1f]};
  // ==========================================
  // program counter
  property p_pc_fixed; O_PC[31:26] == 6'h00 && O_PC[0] == 1'b0; endproperty
  a_pc_fixed: assert property (p_pc_fixed)
    else $error("pc fixed bits not zero");
  property p_pc_add; I_PC_OP == PC_ADD |=> O_PC ==
    {6'h00, 26'($past(O_PC) + $past(I_PC_OPERAND)) & 26'h3fffffe};
  endproperty
  a_pc_add: assert property (p_pc_add)
    else $error("pc add wrong");
  property p_pc_load; I_PC_OP == PC_LOAD |=>
    O_PC == ($past(I_PC_OPERAND) & 32'h03fffffe); endproperty
  a_pc_load: assert property (p_pc_load)
    else $error("pc load wrong");
  property p_pc_hold; I_PC_OP == PC_HOLD |=> $stable(O_PC); endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc moved on hold");
  // ==========================================
  // general registers
  property p_zero; I_GPR_RADDR_B == 5'h00 |=> O_GPR_RDATA_B == 32'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("register zero not zero");
  property p_short; I_SHORT_MEM_INSTR && I_GPR_RADDR_B == 5'h1e |=>
    O_GPR_RDATA_A == O_GPR_RDATA_B; endproperty
  a_short: assert property (p_short)
    else $error("short access base wrong");
  property p_bypass; I_GPR_WE && I_GPR_WADDR != 5'h00 &&
    I_GPR_RADDR_B == I_GPR_WADDR |=> O_GPR_RDATA_B == $past(I_GPR_WDATA);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("written value not read back");
  // ==========================================
  // system registers
  property p_sys_hold; !I_STORE_SYSREG_INSTR |=> $stable(O_SYSREG_RDATA);
  endproperty
  a_sys_hold: assert property (p_sys_hold)
    else $error("system read data moved");
  property p_rsv; I_STORE_SYSREG_INSTR && rsv |=> O_SYSREG_RDATA == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved number read not zero");
  property p_status; I_LOAD_SYSREG_INSTR && I_SYSREG_NUM == 5'h05 |=>
    O_PSW == $past(I_SYSREG_WDATA); endproperty
  a_status: assert property (p_status)
    else $error("status word load lost");
endmodule // cpu_regs_properties
bind cpu_regs cpu_regs_properties i_props (.*);

// *** verif/cpu_regs_tb_top.sv ***
// self-checking bench of the cpu register file
`timescale 1ns/1ps
module cpu_regs_tb_top;
  import cpu_regs_pkg::*;
  logic I_MCLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_SHORT_MEM_INSTR, I_GPR_WE, I_LOAD_SYSREG_INSTR, I_PSW_HW_WE;
  logic I_STORE_SYSREG_INSTR, I_DEBUG_TRAP_INSTR, I_ISRC_WE;
  logic [1:0] I_PC_OP, I_RET_SRC;
  logic [4:0] I_GPR_RADDR_A, I_GPR_RADDR_B, I_GPR_WADDR, I_SYSREG_NUM;
  logic [31:0] I_GPR_WDATA, I_PC_OPERAND, I_SYSREG_WDATA, I_ISRC_DATA;
  logic [31:0] I_PSW_HW_DATA, O_GPR_RDATA_A, O_GPR_RDATA_B, O_PC;
  logic [31:0] O_SYSREG_RDATA, O_PSW;
  int errors = 0;
  int checks_done = 0;
  word_type a, b, e;
  always #4 I_MCLK = ~I_MCLK;
  cpu_regs i_dut (.*);
  cpu_pipe_model i_pipe (.*);
  task automatic check(input word_type seen, input word_type exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    check(O_PSW, 32'h00000020);
    check(O_PC, 32'h00000000);
  endtask
  task automatic t_gpr();
    for (int i = 0; i < 32; i++) begin
      i_pipe.gpr_wr(5'(i), 32'ha5000000 | i);
    end
    for (int i = 0; i < 32; i++) begin
      e = (i == 0) ? 32'h0 : 32'ha5000000 | i;
      i_pipe.gpr_rd(5'(i), 5'(31 - i), 1'b0, a, b);
      check(a, e);
      e = (i == 31) ? 32'h0 : 32'ha5000000 | (31 - i);
      check(b, e);
    end
    i_pipe.gpr_rd(5'h01, 5'h1e, 1'b1, a, b);
    check(a, 32'ha500001e);
    check(b, 32'ha500001e);
    i_pipe.gpr_wr_rd(5'h07, 32'h0000beef, b);
    check(b, 32'h0000beef);
    i_pipe.gpr_wr_rd(5'h00, 32'hffffffff, b);
    check(b, 32'h00000000);
  endtask
  task automatic t_pc();
    i_pipe.pc_op(PC_LOAD, 32'hffffffff, RET_IRQ, a);
    check(a, 32'h03fffffe);
    i_pipe.pc_op(PC_ADD, 32'h00000006, RET_IRQ, a);
    check(a, 32'h00000004);
    i_pipe.pc_op(PC_HOLD, 32'h00000040, RET_IRQ, a);
    check(a, 32'h00000004);
  endtask
  task automatic t_sys();
    for (int n = 0; n < 32; n++) begin
      i_pipe.sys_wr(5'(n), 32'h5a000100 | n, 1'b0);
      i_pipe.sys_rd(5'(n), a);
      e = (n < 4 || n == 5 || n == 16 || n == 17 || n == 20) ?
          32'h5a000100 | n : 32'h0;
      check(a, e);
    end
    check(O_PSW, 32'h5a000105);
    i_pipe.psw_wr(32'h000000c0, 1'b0);
    check(O_PSW, 32'h000000c0);
    i_pipe.sys_rd(5'h05, a);
    check(a, 32'h000000c0);
    i_pipe.psw_wr(32'h0000000f, 1'b1);
    check(O_PSW, 32'hfffffff0);
    i_pipe.sys_wr(5'h13, 32'h00000777, 1'b1);
    i_pipe.sys_rd(5'h13, a);
    check(a, 32'h00000777);
    i_pipe.isrc_wr(32'h00000011);
    i_pipe.sys_rd(5'h04, a);
    check(a, 32'h00000011);
  endtask
  task automatic t_ret();
    ret_src_type s[4] = '{RET_IRQ, RET_NMI, RET_TABLE, RET_DEBUG};
    regnum_type r[4] = '{5'h00, 5'h02, 5'h10, 5'h12};
    // odd, oversized saved values make the dropped bits visible
    for (int k = 0; k < 4; k++) begin
      i_pipe.sys_wr(r[k], 32'hfc000101 + k * 16, 1'b1);
      i_pipe.pc_op(PC_RETURN, 32'h0, s[k], a);
      check(a, 32'h00000100 + k * 16);
    end
  endtask
  initial begin
    repeat (16) @(negedge I_MCLK);
    I_RST = 1'b0;
    t_reset();
    t_gpr();
    t_pc();
    t_sys();
    t_ret();
    give_verdict();
  end
endmodule // cpu_regs_tb_top
